// File: shared/gmx_pkg.sv
package gmx_pkg;

	// System clock and the transmit clocks generated from it
	localparam int unsigned CLK_HZ        = 200_000_000;
	localparam int unsigned TXCLK_FAST_HZ = 25_000_000;
	localparam int unsigned TXCLK_SLOW_HZ = 2_500_000;
	// Half periods of the generated transmit clock, in system clock cycles
	localparam logic [5:0]  HALF_FAST     = 6'(CLK_HZ / (2 * TXCLK_FAST_HZ));
	localparam logic [5:0]  HALF_SLOW     = 6'(CLK_HZ / (2 * TXCLK_SLOW_HZ));

	// Cycles after reset release before the straps are taken
	localparam logic [1:0]  STRAP_SETTLE  = 2'h3;

	// Register byte offsets on the Avalon-MM slave
	localparam int unsigned ADDR_W        = 4;
	localparam logic [3:0]  REG_CTRL      = 4'h0;
	localparam logic [3:0]  REG_STATUS    = 4'h4;

	// Control register fields
	localparam int unsigned CTRL_ISOLATE  = 0;
	localparam int unsigned CTRL_SPEED    = 1;
	localparam int unsigned CTRL_DUPLEX   = 3;
	localparam int unsigned CTRL_REFCLK   = 4;

	// Status register fields
	localparam int unsigned STS_COMBINED  = 0;
	localparam int unsigned STS_REFSTRAP  = 1;
	localparam int unsigned STS_ISOLATED  = 2;
	localparam int unsigned STS_SPEED     = 3;
	localparam int unsigned STS_TXACT     = 5;
	localparam int unsigned STS_CARRIER   = 6;
	localparam int unsigned STS_STRAPPED  = 7;

	typedef enum logic [1:0]
	{
		SPEED_10   = 2'h0,
		SPEED_100  = 2'h1,
		SPEED_1000 = 2'h2
	} gmx_speed_t;

	// Values after reset
	localparam logic        ISOLATE_RST   = 1'b0;
	localparam gmx_speed_t  SPEED_RST     = SPEED_1000;
	localparam logic        DUPLEX_RST    = 1'b1;

	typedef enum logic [1:0]
	{
		STRAP_WAIT = 2'h1,
		STRAP_DONE = 2'h2
	} gmx_strap_state_t;

	// Transmit group as seen at the MAC pins and handed to the line side
	typedef struct packed
	{
		logic       en;
		logic       er;
		logic [7:0] data;
	} gmx_tx_word_t;

	// Receive group from the line side and on the MAC pins
	typedef struct packed
	{
		logic       dv;
		logic       er;
		logic [7:0] data;
	} gmx_rx_word_t;

endpackage

// File: core/gmx_phy_mii.sv
`timescale 1ns/100ps

// Notes on behaviour
// - Gigabit transmit and receive each carry a byte, on independent groups.
// - Gigabit: MAC supplies 125 MHz transmit clock, device drives recovered receive clock.
// - Gigabit transmit enable, data and error captured on rising transmit clock edge.
// - Gigabit receive valid, data and error presented for MAC rising-edge capture.
// - Carrier sense and collision driven unsynchronised to transmit or receive clock.
// - Gigabit half duplex is never used; a request for it is forced full.
// - Interface-select strap low at reset selects the combined byte/nibble interface.
// - Combined interface runs 10, 100 and 1000; nibble at 10/100, byte at 1000.
// - Clock-output strap high at reset enables reference clock and sets its control bit.
// - Isolate tri-states all interface outputs, ignores inputs; reference clock keeps running.
// - At 10/100 the device generates transmit clock: 25 MHz or 2.5 MHz.
// - At 10/100 the device drives the recovered receive clock, 25 or 2.5 MHz.
// - At 10/100 receive valid, nibble and error change with the receive clock.
// - At 10/100 transmit and receive each carry a nibble, on independent groups.
// - Interface-select strap high at reset selects the reduced-pin interface instead; here all interface outputs just stay tri-stated.
module gmx_phy_mii
(
	input  wire logic                          clk,
	input  wire logic                          rstn,
	input  wire logic                          gtx_clk,
	input  wire logic                          rec_clk,
	input  wire logic                          ref_clk_125,
	input  wire logic [gmx_pkg::ADDR_W-1:0]    avs_address,
	input  wire logic                          avs_read,
	input  wire logic                          avs_write,
	input  wire logic [31:0]                   avs_writedata,
	output logic      [31:0]                   avs_readdata,
	output logic                               avs_waitrequest,
	input  wire logic                          iface_select_strap,
	input  wire logic                          refclk_out_enable_strap,
	input  wire gmx_pkg::gmx_tx_word_t         mac_tx,
	output logic                               tx_clk_pin,
	output logic                               tx_clk_pin_oe,
	output logic                               rx_clk_pin,
	output logic                               rx_clk_pin_oe,
	output gmx_pkg::gmx_rx_word_t              rx_pins,
	output logic                               rx_pins_oe,
	output logic                               crs_pin,
	output logic                               crs_pin_oe,
	output logic                               col_pin,
	output logic                               col_pin_oe,
	output logic                               refclk_125_output,
	input  wire gmx_pkg::gmx_rx_word_t         line_rx,
	input  wire logic                          line_carrier,
	output gmx_pkg::gmx_tx_word_t              gig_tx,
	output gmx_pkg::gmx_tx_word_t              mii_tx,
	output logic                               mii_tx_valid
);

	// Register state
	logic                      isolate_control_bit;
	logic                      refclk_out_enable_bit;
	gmx_pkg::gmx_speed_t       speed;
	logic                      full_duplex;
	logic                      combined_mode;
	logic                      refclk_strap_seen;
	logic                      ack;
	// Strap capture
	gmx_pkg::gmx_strap_state_t strap_state;
	logic [1:0]                settle_cnt;
	logic [1:0]                strap_s1;
	logic [1:0]                strap_s2;
	// Transmit pins and carrier brought into the system clock
	gmx_pkg::gmx_tx_word_t     mac_tx_s1;
	gmx_pkg::gmx_tx_word_t     mac_tx_s2;
	logic                      carrier_s1;
	logic                      carrier_s2;
	// Generated transmit clock
	logic [5:0]                div_cnt;
	logic                      tx_clk_gen;
	// Interface enables per domain
	logic                      iface_on;
	logic                      mii_on;
	logic                      gig_on;
	logic                      half_duplex;
	logic                      tx_active;
	logic [1:0]                gtx_on_sync;
	logic [1:0]                rec_on_sync;
	logic [1:0]                rec_mii_sync;
	logic [1:0]                ref_en_sync;
	logic                      ref_gate;

	// Interface is live only in combined mode and outside isolate
	assign iface_on    = combined_mode && !isolate_control_bit;
	assign gig_on      = iface_on && (speed == gmx_pkg::SPEED_1000);
	assign mii_on      = iface_on && (speed != gmx_pkg::SPEED_1000);
	assign half_duplex = !full_duplex && (speed != gmx_pkg::SPEED_1000);
	assign tx_active   = iface_on && mac_tx_s2.en;

	// Strap synchroniser; straps are pins with no relation to clk
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			strap_s1 <= 2'h0;
			strap_s2 <= 2'h0;
		end
		else
		begin
			strap_s1 <= {refclk_out_enable_strap, iface_select_strap};
			strap_s2 <= strap_s1;
		end
	end

	// Straps are taken once, a few cycles after release, so the synchroniser has filled
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			strap_state       <= gmx_pkg::STRAP_WAIT;
			settle_cnt        <= 2'h0;
			combined_mode     <= 1'b0;
			refclk_strap_seen <= 1'b0;
		end
		else
		begin
			unique case (strap_state)
				gmx_pkg::STRAP_WAIT:
				begin
					settle_cnt <= settle_cnt + 2'h1;
					if (settle_cnt == gmx_pkg::STRAP_SETTLE)
					begin
						combined_mode     <= !strap_s2[0];
						refclk_strap_seen <= strap_s2[1];
						strap_state       <= gmx_pkg::STRAP_DONE;
					end
				end
				gmx_pkg::STRAP_DONE:
				begin
					strap_state <= gmx_pkg::STRAP_DONE;
				end
				default:
				begin
					strap_state <= gmx_pkg::STRAP_WAIT;
				end
			endcase
		end
	end

	// Avalon handshake: one wait cycle, then the request is taken
	assign avs_waitrequest = (avs_read || avs_write) && !ack;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ack <= 1'b0;
		end
		else
		begin
			ack <= (avs_read || avs_write) && !ack;
		end
	end

	// Control register writes; the strap result lands in the clock-output bit once
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			isolate_control_bit   <= gmx_pkg::ISOLATE_RST;
			speed                 <= gmx_pkg::SPEED_RST;
			full_duplex           <= gmx_pkg::DUPLEX_RST;
			refclk_out_enable_bit <= 1'b0;
		end
		else if (strap_state == gmx_pkg::STRAP_WAIT && settle_cnt == gmx_pkg::STRAP_SETTLE)
		begin
			refclk_out_enable_bit <= strap_s2[1];
		end
		else if (avs_write && ack && avs_address == gmx_pkg::REG_CTRL)
		begin
			isolate_control_bit   <= avs_writedata[gmx_pkg::CTRL_ISOLATE];
			refclk_out_enable_bit <= avs_writedata[gmx_pkg::CTRL_REFCLK];
			// Reserved speed code falls back to gigabit
			if (avs_writedata[gmx_pkg::CTRL_SPEED +: 2] == 2'h3)
			begin
				speed <= gmx_pkg::SPEED_1000;
			end
			else
			begin
				speed <= gmx_pkg::gmx_speed_t'(avs_writedata[gmx_pkg::CTRL_SPEED +: 2]);
			end
			// Gigabit never runs half duplex, so a half-duplex request there is forced full
			full_duplex <= avs_writedata[gmx_pkg::CTRL_DUPLEX]
				|| (avs_writedata[gmx_pkg::CTRL_SPEED +: 2] >= 2'h2);
		end
	end

	// Read data registered in the wait cycle; unmapped offsets read zero
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			avs_readdata <= 32'h0;
		end
		else if (avs_read && !ack)
		begin
			avs_readdata <= 32'h0;
			if (avs_address == gmx_pkg::REG_CTRL)
			begin
				avs_readdata[gmx_pkg::CTRL_ISOLATE]    <= isolate_control_bit;
				avs_readdata[gmx_pkg::CTRL_SPEED +: 2] <= speed;
				avs_readdata[gmx_pkg::CTRL_DUPLEX]     <= full_duplex;
				avs_readdata[gmx_pkg::CTRL_REFCLK]     <= refclk_out_enable_bit;
			end
			else if (avs_address == gmx_pkg::REG_STATUS)
			begin
				avs_readdata[gmx_pkg::STS_COMBINED]    <= combined_mode;
				avs_readdata[gmx_pkg::STS_REFSTRAP]    <= refclk_strap_seen;
				avs_readdata[gmx_pkg::STS_ISOLATED]    <= !iface_on;
				avs_readdata[gmx_pkg::STS_SPEED +: 2]  <= speed;
				avs_readdata[gmx_pkg::STS_TXACT]       <= tx_active;
				avs_readdata[gmx_pkg::STS_CARRIER]     <= carrier_s2;
				avs_readdata[gmx_pkg::STS_STRAPPED]    <= (strap_state == gmx_pkg::STRAP_DONE);
			end
		end
	end

	// MAC transmit pins and line carrier pass two flip-flops before use on the system clock
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			mac_tx_s1  <= '0;
			mac_tx_s2  <= '0;
			carrier_s1 <= 1'b0;
			carrier_s2 <= 1'b0;
		end
		else
		begin
			mac_tx_s1  <= mac_tx;
			mac_tx_s2  <= mac_tx_s1;
			carrier_s1 <= line_carrier;
			carrier_s2 <= carrier_s1;
		end
	end

	// Transmit clock divider for 10/100; held low at gigabit
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			div_cnt    <= 6'h0;
			tx_clk_gen <= 1'b0;
		end
		else if (!mii_on)
		begin
			div_cnt    <= 6'h0;
			tx_clk_gen <= 1'b0;
		end
		else if (div_cnt == ((speed == gmx_pkg::SPEED_100) ? gmx_pkg::HALF_FAST : gmx_pkg::HALF_SLOW) - 6'h1)
		begin
			div_cnt    <= 6'h0;
			tx_clk_gen <= !tx_clk_gen;
		end
		else
		begin
			div_cnt <= div_cnt + 6'h1;
		end
	end

	// Transmit clock pin driven only while the nibble path is live
	assign tx_clk_pin    = tx_clk_gen;
	assign tx_clk_pin_oe = mii_on;

	// Nibble capture at the rising edge of the generated clock; MAC data launched
	// at the previous rise has long settled through the synchroniser by then
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			mii_tx       <= '0;
			mii_tx_valid <= 1'b0;
		end
		else
		begin
			mii_tx_valid <= 1'b0;
			if (mii_on && !tx_clk_gen && div_cnt == ((speed == gmx_pkg::SPEED_100) ?
				gmx_pkg::HALF_FAST : gmx_pkg::HALF_SLOW) - 6'h1)
			begin
				mii_tx.en    <= mac_tx_s2.en;
				mii_tx.er    <= mac_tx_s2.er;
				mii_tx.data  <= {4'h0, mac_tx_s2.data[3:0]};
				mii_tx_valid <= 1'b1;
			end
		end
	end

	// Carrier and collision from system-clock flops, unrelated to either link clock
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			crs_pin    <= 1'b0;
			col_pin    <= 1'b0;
			crs_pin_oe <= 1'b0;
			col_pin_oe <= 1'b0;
		end
		else
		begin
			crs_pin    <= iface_on && (carrier_s2 || (half_duplex && tx_active));
			col_pin    <= iface_on && half_duplex && tx_active && carrier_s2;
			crs_pin_oe <= iface_on;
			col_pin_oe <= iface_on;
		end
	end

	// Gigabit enable crossed into the MAC clock; bytes wait for it, so ignored inputs read as idle
	always_ff @(posedge gtx_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			gtx_on_sync <= 2'h0;
			gig_tx      <= '0;
		end
		else
		begin
			gtx_on_sync <= {gtx_on_sync[0], gig_on};
			if (gtx_on_sync[1])
			begin
				gig_tx <= mac_tx;
			end
			else
			begin
				gig_tx <= '0;
			end
		end
	end

	// Enable and nibble mode crossed into the recovered clock domain; the receive group is
	// launched on the recovered clock rise, so the MAC samples it a full period later
	always_ff @(posedge rec_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rec_on_sync  <= 2'h0;
			rec_mii_sync <= 2'h0;
			rx_pins      <= '0;
			rx_pins_oe   <= 1'b0;
		end
		else
		begin
			rec_on_sync  <= {rec_on_sync[0], iface_on};
			rec_mii_sync <= {rec_mii_sync[0], mii_on};
			rx_pins_oe   <= rec_on_sync[1];
			if (!rec_on_sync[1])
			begin
				rx_pins <= '0;
			end
			else if (rec_mii_sync[1])
			begin
				rx_pins.dv   <= line_rx.dv;
				rx_pins.er   <= line_rx.er;
				rx_pins.data <= {4'h0, line_rx.data[3:0]};
			end
			else
			begin
				rx_pins <= line_rx;
			end
		end
	end

	// Recovered clock forwarded to the MAC at whatever rate the line runs
	assign rx_clk_pin    = rec_clk;
	assign rx_clk_pin_oe = rx_pins_oe;

	// Reference clock gate: enable synchronised, then changed on the low phase so no runt pulse
	always_ff @(posedge ref_clk_125 or negedge rstn)
	begin
		if (!rstn)
		begin
			ref_en_sync <= 2'h0;
		end
		else
		begin
			ref_en_sync <= {ref_en_sync[0], refclk_out_enable_bit};
		end
	end
	always_ff @(negedge ref_clk_125 or negedge rstn)
	begin
		if (!rstn)
		begin
			ref_gate <= 1'b0;
		end
		else
		begin
			ref_gate <= ref_en_sync[1];
		end
	end

	// Isolate does not touch the reference clock
	assign refclk_125_output = ref_clk_125 && ref_gate;
endmodule

// File: tb/gmx_phy_mii_asserts.sv
`timescale 1ns/100ps
// Watches the device ports only; internal mode is inferred from the enables
module gmx_phy_mii_asserts
(
	input wire logic			clk,
	input wire logic			rstn,
	input wire logic			gtx_clk,
	input wire logic			rec_clk,
	input wire logic [3:0]			avs_address,
	input wire logic			avs_read,
	input wire logic			avs_write,
	input wire logic [31:0]			avs_readdata,
	input wire logic			avs_waitrequest,
	input wire logic			iface_select_strap,
	input wire gmx_pkg::gmx_tx_word_t	mac_tx,
	input wire logic			tx_clk_pin,
	input wire logic			tx_clk_pin_oe,
	input wire gmx_pkg::gmx_rx_word_t	rx_pins,
	input wire logic			rx_pins_oe,
	input wire logic			crs_pin,
	input wire logic			crs_pin_oe,
	input wire gmx_pkg::gmx_rx_word_t	line_rx,
	input wire logic			line_carrier,
	input wire gmx_pkg::gmx_tx_word_t	gig_tx,
	input wire gmx_pkg::gmx_tx_word_t	mii_tx,
	input wire logic			mii_tx_valid
);
	// Bus handshake: one wait cycle, then the answer
	property p_wait_first;
		@(posedge clk) disable iff (!rstn) (avs_read || avs_write) && !$past(avs_read || avs_write) |-> avs_waitrequest;
	endproperty
	a_wait_first: assert property (p_wait_first) else $error("no wait cycle");
	property p_wait_one;
		@(posedge clk) disable iff (!rstn) (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("wait too long");
	property p_unmapped;
		@(posedge clk) disable iff (!rstn) avs_read && !avs_waitrequest && avs_address != gmx_pkg::REG_CTRL
			&& avs_address != gmx_pkg::REG_STATUS |-> avs_readdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_gig_full;
		@(posedge clk) disable iff (!rstn) avs_read && !avs_waitrequest && avs_address == gmx_pkg::REG_CTRL
			&& avs_readdata[2:1] == 2'h2 |-> avs_readdata[3];
	endproperty
	a_gig_full: assert property (p_gig_full) else $error("gigabit half duplex");
	// Nibble captures: at a transmit clock rise, never closer than the fast period
	property p_valid_space;
		@(posedge clk) disable iff (!rstn) mii_tx_valid |=> (!mii_tx_valid)[*7];
	endproperty
	a_valid_space: assert property (p_valid_space) else $error("captures too close");
	property p_valid_edge;
		@(posedge clk) disable iff (!rstn) mii_tx_valid |-> $rose(tx_clk_pin) && tx_clk_pin_oe && mii_tx.data[7:4] == 4'h0;
	endproperty
	a_valid_edge: assert property (p_valid_edge) else $error("capture off edge");
	property p_iso_quiet;
		@(posedge clk) disable iff (!rstn) mii_tx_valid |-> ##[0:3] crs_pin_oe;
	endproperty
	a_iso_quiet: assert property (p_iso_quiet) else $error("capture while off");
	property p_crs;
		@(posedge clk) disable iff (!rstn) line_carrier [*4] ##0 crs_pin_oe |-> crs_pin;
	endproperty
	a_crs: assert property (p_crs) else $error("carrier not shown");
	property p_strap;
		@(posedge clk) disable iff (!rstn) iface_select_strap |-> !crs_pin_oe && !tx_clk_pin_oe;
	endproperty
	a_strap: assert property (p_strap) else $error("live in reduced mode");
	property p_gig_cap;
		@(posedge gtx_clk) disable iff (!rstn) gig_tx != 10'h000 |-> gig_tx == $past(mac_tx);
	endproperty
	a_gig_cap: assert property (p_gig_cap) else $error("byte capture wrong");
	property p_rx;
		@(posedge rec_clk) disable iff (!rstn) rx_pins_oe && $past(rx_pins_oe) |->
			rx_pins.dv == $past(line_rx.dv) && rx_pins.er == $past(line_rx.er);
	endproperty
	a_rx: assert property (p_rx) else $error("receive flags wrong");
endmodule

bind gmx_phy_mii gmx_phy_mii_asserts u_chk (.clk, .rstn, .gtx_clk, .rec_clk, .avs_address, .avs_read, .avs_write,
	.avs_readdata, .avs_waitrequest, .iface_select_strap, .mac_tx, .tx_clk_pin, .tx_clk_pin_oe, .rx_pins,
	.rx_pins_oe, .crs_pin, .crs_pin_oe, .line_rx, .line_carrier, .gig_tx, .mii_tx, .mii_tx_valid);

// File: tb/gmx_mac_model.sv
`timescale 1ns/100ps
// MAC transmit side; prev holds the word the device should take at each edge
module gmx_mac_model
(
	input wire logic			gtx_clk,
	input wire logic			tx_clk_pin,
	input wire logic			tx_clk_pin_oe,
	input wire logic			gig,
	output gmx_pkg::gmx_tx_word_t	mac_tx,
	output gmx_pkg::gmx_tx_word_t	prev
);
	logic [9:0]	cnt;
	// A released clock pin reads low, so a tri-stated clock never strobes
	wire		strobe = gig ? gtx_clk : (tx_clk_pin & tx_clk_pin_oe);

	initial
	begin
		cnt = 10'h000;
		mac_tx = '0;
		prev = '0;
	end

	// Upper nibble keeps changing at 10/100 so masking is really tested
	always @(posedge strobe)
	begin
		cnt <= cnt + 10'h001;
		prev <= mac_tx;
		mac_tx <= gmx_pkg::gmx_tx_word_t'(cnt * 10'h0B5);
	end
endmodule

// File: tb/gmx_phy_mii_tb_top.sv
`timescale 1ns/100ps
module gmx_phy_mii_tb_top;
	typedef struct {logic [31:0] wr; logic [31:0] rd; int per; logic oe; logic rf;} gmx_row_t;
	logic				clk, rstn, gtx_clk, rec_clk, ref_clk_125, gig, chk;
	logic [3:0]			avs_address;
	logic				avs_read, avs_write, avs_waitrequest;
	logic [31:0]			avs_writedata, avs_readdata, d;
	logic				iface_select_strap, refclk_out_enable_strap, line_carrier;
	logic				tx_clk_pin, tx_clk_pin_oe, rx_clk_pin, rx_clk_pin_oe, rx_pins_oe;
	logic				crs_pin, crs_pin_oe, col_pin, col_pin_oe, refclk_125_output, mii_tx_valid;
	gmx_pkg::gmx_tx_word_t		mac_tx, prev, gig_tx, mii_tx;
	gmx_pkg::gmx_rx_word_t		rx_pins, line_rx, lprev;
	int				errors, n_tests, rh, rf_cnt, n, a, gexp, roe;
	gmx_row_t			rows [5];

	gmx_phy_mii DUT (.clk, .rstn, .gtx_clk, .rec_clk, .ref_clk_125, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_readdata, .avs_waitrequest, .iface_select_strap, .refclk_out_enable_strap, .mac_tx,
		.tx_clk_pin, .tx_clk_pin_oe, .rx_clk_pin, .rx_clk_pin_oe, .rx_pins, .rx_pins_oe, .crs_pin, .crs_pin_oe,
		.col_pin, .col_pin_oe, .refclk_125_output, .line_rx, .line_carrier, .gig_tx, .mii_tx, .mii_tx_valid);
	gmx_mac_model u_mac (.gtx_clk, .tx_clk_pin, .tx_clk_pin_oe, .gig, .mac_tx, .prev);

	// Clocks; the MAC byte clock stands still outside gigabit
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial
	begin
		gtx_clk = 1'b0;
		forever #7.5 gtx_clk = ~gtx_clk & gig;
	end
	initial
	begin
		rec_clk = 1'b0;
		// Half period is set by the stimulus at time zero; a zero delay would spin
		wait (rh > 0);
		forever #(rh) rec_clk = ~rec_clk;
	end
	initial
	begin
		ref_clk_125 = 1'b0;
		forever #4 ref_clk_125 = ~ref_clk_125;
	end

	// Line side feeds a new word every rising receive edge
	always @(posedge rec_clk)
	begin
		lprev <= line_rx;
		line_rx <= gmx_pkg::gmx_rx_word_t'(line_rx + 10'h0C7);
	end
	always @(posedge refclk_125_output) rf_cnt++;
	always @(negedge gtx_clk) if (chk) cmp_p(gig_tx, gexp ? prev : 10'h000);
	always @(negedge rec_clk) if (chk) cmp_p(rx_pins, !roe ? 10'h000 : gig ? lprev : lprev & 10'h30F);
	always @(negedge clk) if (chk && mii_tx_valid === 1'b1) cmp_p(mii_tx, {prev[9:8], 4'h0, prev[3:0]});

	task automatic cmp_w(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			errors++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_p(input logic [9:0] got, input logic [9:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			errors++;
			$display("Error at %0t: pins %h, expected %h", $time, got, exp);
		end
	endtask

	// One Avalon transfer; held until waitrequest is seen low
	task automatic bus(input logic we, input logic [3:0] ad, input logic [31:0] wd);
		int w;
		w = 0;
		@(posedge clk);
		avs_read <= !we;
		avs_write <= we;
		avs_address <= ad;
		avs_writedata <= wd;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0 && w < 50)
		begin
			w++;
			@(posedge clk);
		end
		if (w == 50) errors++;
		d = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic do_reset(input logic sel, input logic rf);
		@(posedge clk);
		rstn <= 1'b0;
		iface_select_strap <= sel;
		refclk_out_enable_strap <= rf;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		repeat (6) @(posedge clk);
	endtask

	// Waits for a capture pulse under a bound, counting cycles
	task automatic wait_valid();
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (mii_tx_valid !== 1'b1 && n < 200);
	endtask

	task automatic summarize;
		if (errors == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial
	begin
		#300us;
		errors++;
		summarize;
	end

	initial
	begin
		{rstn, chk, avs_read, avs_write, avs_address, avs_writedata, line_carrier} = '0;
		{errors, n_tests, rf_cnt, gexp, roe} = '0;
		gig = 1'b1;
		rh = 4;
		line_rx = '0;
		iface_select_strap = 1'b0;
		refclk_out_enable_strap = 1'b1;
		rows = '{'{32'h14, 32'h1C, 0, 1, 1}, '{32'h1A, 32'h1A, 8, 1, 1}, '{32'h18, 32'h18, 80, 1, 1},
			'{32'h06, 32'h0C, 0, 1, 0}, '{32'h1F, 32'h1D, 0, 0, 1}};
		do_reset(1'b0, 1'b1);
		bus(1'b0, gmx_pkg::REG_STATUS, 32'h0);
		cmp_w(d & 32'hFFFFFFDF, 32'h93);
		bus(1'b0, gmx_pkg::REG_CTRL, 32'h0);
		cmp_w(d, 32'h1C);
		bus(1'b1, 4'h8, 32'hFFFFFFFF);
		bus(1'b0, 4'h8, 32'h0);
		cmp_w(d, 32'h0);
		// Table of modes: speed, duplex, isolate and clock output
		foreach (rows[i])
		begin
			chk = 1'b0;
			gig = rows[i].per == 0;
			rh = rows[i].per == 0 ? 4 : rows[i].per == 8 ? 20 : 200;
			bus(1'b1, gmx_pkg::REG_CTRL, rows[i].wr);
			bus(1'b0, gmx_pkg::REG_CTRL, 32'h0);
			cmp_w(d, rows[i].rd);
			repeat (400) @(posedge clk);
			gexp = rows[i].oe && gig;
			roe = rows[i].oe;
			chk = 1'b1;
			cmp_w({crs_pin_oe, col_pin_oe, rx_pins_oe, rx_clk_pin_oe, tx_clk_pin_oe},
				{{4{rows[i].oe}}, rows[i].oe && !gig});
			cmp_w(rx_clk_pin, rec_clk);
			wait_valid();
			if (rows[i].per != 0)
				wait_valid();
			cmp_w(n, rows[i].per == 0 ? 200 : rows[i].per);
			a = rf_cnt;
			repeat (40) @(posedge clk);
			cmp_w(rf_cnt != a, rows[i].rf);
			repeat (100) @(posedge clk);
		end
		chk = 1'b0;
		// Collision only in half duplex at 100 with carrier and transmit
		gig = 1'b0;
		rh = 20;
		bus(1'b1, gmx_pkg::REG_CTRL, 32'h12);
		line_carrier <= 1'b1;
		a = 0;
		repeat (300) @(posedge clk) a = a | col_pin;
		cmp_w({crs_pin, 1'(a)}, 2'b11);
		bus(1'b1, gmx_pkg::REG_CTRL, 32'h1A);
		repeat (10) @(posedge clk);
		a = 0;
		repeat (200) @(posedge clk) a = a | col_pin;
		line_carrier <= 1'b0;
		repeat (6) @(posedge clk);
		cmp_w({crs_pin, 1'(a)}, 2'b00);
		// Mid-run reset into the reduced-pin strap, clock output off
		do_reset(1'b1, 1'b0);
		repeat (20) @(posedge clk);
		bus(1'b0, gmx_pkg::REG_STATUS, 32'h0);
		cmp_w(d[2:0], 3'b100);
		bus(1'b0, gmx_pkg::REG_CTRL, 32'h0);
		cmp_w(d, 32'h0C);
		a = rf_cnt;
		repeat (40) @(posedge clk);
		cmp_w({crs_pin_oe, col_pin_oe, rx_pins_oe, tx_clk_pin_oe, 1'(rf_cnt != a)}, 5'h00);
		summarize;
	end
endmodule
